// file: verilog/spt_timing_regs.v
// Self polling timing and status block with its AXI4-Lite register slave
//
// The AXI4-Lite register port was left to the implementer.
`include "spt_defines.vh"
module spt_timing_regs #(
    parameter [7:0] SERIAL_NUMBER = 8'h5A   // Arbitrary value, set per chip
) (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        wakeFound,
    input  wire [1:0]  wakeChannel,
    input  wire        carrierSeen,
    output wire        receiverOn,
    output wire        wakeSearchOn,
    output wire        configBSelect,
    output wire        irq
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam [1:0] ST_STOP  = 2'h0;
    localparam [1:0] ST_ON    = 2'h1;
    localparam [1:0] ST_OFF   = 2'h2;
    localparam [1:0] ST_WOKEN = 2'h3;

    reg        awReady_q, wReady_q, arReady_q, bValid_q, rValid_q;
    reg        awGot_q, wGot_q;
    reg  [5:0] wrIdx_q;
    reg  [7:0] wrData_q;
    reg        wrStrb_q;
    reg  [1:0] bResp_q, rResp_q;
    reg  [31:0] rData_q;

    reg  [1:0] found_channel_code_q;
    reg  [1:0] polling_variant_select_q;
    reg        continuous_wake_search_enable_q;
    reg        active_idle_enable_q;
    reg  [7:0] reference_tick_reload_q;
    reg  [13:0] off_time_setting_q;
    reg  [4:0] active_period_setting_q;
    reg  [7:0] idle_period_setting_q;
    reg        operating_mode_select_q;
    reg        dualConfig_q;
    reg  [13:0] onTimeA_q, onTimeB_q;
    reg  [2:0] irqStatus_q, irqEnable_q;
    reg        irq_q;

    reg  [1:0] state_q;
    reg        cfgB_q;
    reg  [14:0] intervalCnt_q;
    reg        firstTick_q;
    reg        activePhase_q;
    reg  [8:0] phaseCnt_q;
    reg        rxOn_q, searchOn_q;
    reg  [2:0] events;
    reg  [2:0] irqClear;
    reg  [2:0] irqStatus_d;

    wire       refTick;
    wire       doWrite;
    wire [13:0] onTimeCur;
    wire       fastCfg;
    wire       searching;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Fourteen-bit time setting, zero stands for 16384
    function [14:0] expand14;
        input [13:0] v;
        begin
            expand14 = {(v == 14'h0000), v};
        end
    endfunction

    // Eight-bit period count, zero stands for 256
    function [8:0] expand8;
        input [7:0] v;
        begin
            expand8 = {(v == 8'h00), v};
        end
    endfunction

    // Word index of a byte address; low two bits are ignored
    function [5:0] regIndex;
        input [7:0] a;
        begin
            regIndex = a[7:2];
        end
    endfunction

    // ----------------------------------------------------------------
    // Reference tick
    // ----------------------------------------------------------------
    spt_ref_tick #(
        .PRESCALE (`SPT_PRESCALE)
    ) u_ref_tick (
        .clock                 (clock),
        .rst_n                 (rst_n),
        .run                   (operating_mode_select_q),
        .reference_tick_reload (reference_tick_reload_q),
        .tick                  (refTick)
    );

    // ----------------------------------------------------------------
    // AXI4-Lite handshakes
    // ----------------------------------------------------------------
    assign doWrite       = awGot_q && wGot_q && !bValid_q;
    assign s_axi_awready = awReady_q;
    assign s_axi_wready  = wReady_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rresp   = rResp_q;
    assign s_axi_rdata   = rData_q;

    // Address and data taken in either order; the write lands once both are held
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            awReady_q <= 1'b1;
            wReady_q  <= 1'b1;
            awGot_q   <= 1'b0;
            wGot_q    <= 1'b0;
            bValid_q  <= 1'b0;
            bResp_q   <= `SPT_RESP_OKAY;
            wrIdx_q   <= 6'h00;
            wrData_q  <= 8'h00;
            wrStrb_q  <= 1'b0;
        end else begin
            if (awReady_q && s_axi_awvalid) begin
                awReady_q <= 1'b0;
                awGot_q   <= 1'b1;
                wrIdx_q   <= regIndex(s_axi_awaddr);
            end
            if (wReady_q && s_axi_wvalid) begin
                wReady_q <= 1'b0;
                wGot_q   <= 1'b1;
                wrData_q <= s_axi_wdata[7:0];
                wrStrb_q <= s_axi_wstrb[0];
            end
            if (doWrite) begin
                awGot_q  <= 1'b0;
                wGot_q   <= 1'b0;
                bValid_q <= 1'b1;
                case (wrIdx_q)
                    `SPT_IDX_FOUND_CHANNEL, `SPT_IDX_POLL_CONTROL, `SPT_IDX_TICK_DIVIDER,
                    `SPT_IDX_OFF_TIME_LOW, `SPT_IDX_OFF_TIME_HIGH, `SPT_IDX_ACTIVE_PERIODS,
                    `SPT_IDX_IDLE_PERIODS, `SPT_IDX_SERIAL_BYTE0, `SPT_IDX_MODE_CONTROL,
                    `SPT_IDX_ON_TIME_A_LOW, `SPT_IDX_ON_TIME_A_HIGH, `SPT_IDX_ON_TIME_B_LOW,
                    `SPT_IDX_ON_TIME_B_HIGH, `SPT_IDX_IRQ_STATUS, `SPT_IDX_IRQ_ENABLE,
                    `SPT_IDX_IRQ_CLEAR, `SPT_IDX_SEQ_STATE: bResp_q <= `SPT_RESP_OKAY;
                    default: bResp_q <= `SPT_RESP_SLVERR;
                endcase
            end else if (bValid_q && s_axi_bready) begin
                bValid_q  <= 1'b0;
                awReady_q <= 1'b1;
                wReady_q  <= 1'b1;
            end
        end
    end

    // Read data latched at the address edge; write-only registers read as zero
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arReady_q <= 1'b1;
            rValid_q  <= 1'b0;
            rResp_q   <= `SPT_RESP_OKAY;
            rData_q   <= 32'h0000_0000;
        end else if (arReady_q && s_axi_arvalid) begin
            arReady_q <= 1'b0;
            rValid_q  <= 1'b1;
            rResp_q   <= `SPT_RESP_OKAY;
            rData_q   <= 32'h0000_0000;
            case (regIndex(s_axi_araddr))
                `SPT_IDX_FOUND_CHANNEL: rData_q <= {30'h0000_0000, found_channel_code_q};
                `SPT_IDX_SERIAL_BYTE0:  rData_q <= {24'h00_0000, SERIAL_NUMBER};
                `SPT_IDX_IRQ_STATUS:    rData_q <= {29'h0000_0000, irqStatus_q};
                `SPT_IDX_SEQ_STATE:     rData_q <= {27'h000_0000, searchOn_q, rxOn_q, cfgB_q, state_q};
                `SPT_IDX_POLL_CONTROL, `SPT_IDX_TICK_DIVIDER, `SPT_IDX_OFF_TIME_LOW,
                `SPT_IDX_OFF_TIME_HIGH, `SPT_IDX_ACTIVE_PERIODS, `SPT_IDX_IDLE_PERIODS,
                `SPT_IDX_MODE_CONTROL, `SPT_IDX_ON_TIME_A_LOW, `SPT_IDX_ON_TIME_A_HIGH,
                `SPT_IDX_ON_TIME_B_LOW, `SPT_IDX_ON_TIME_B_HIGH, `SPT_IDX_IRQ_ENABLE,
                `SPT_IDX_IRQ_CLEAR: rResp_q <= `SPT_RESP_OKAY;
                default: rResp_q <= `SPT_RESP_SLVERR;
            endcase
        end else if (rValid_q && s_axi_rready) begin
            rValid_q  <= 1'b0;
            arReady_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Software-written settings
    // ----------------------------------------------------------------
    // Only byte lane 0 carries register bits; other lanes are ignored
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            polling_variant_select_q        <= `SPT_RST_POLL_CONTROL;
            continuous_wake_search_enable_q <= 1'b0;
            active_idle_enable_q            <= 1'b0;
            reference_tick_reload_q         <= `SPT_RST_TICK_DIVIDER;
            off_time_setting_q              <= {`SPT_RST_OFF_TIME_HIGH, `SPT_RST_OFF_TIME_LOW};
            active_period_setting_q         <= `SPT_RST_ACTIVE_PERIODS;
            idle_period_setting_q           <= `SPT_RST_IDLE_PERIODS;
            operating_mode_select_q         <= 1'b0;
            dualConfig_q                    <= 1'b0;
            onTimeA_q                       <= {`SPT_RST_ON_TIME_HIGH, `SPT_RST_ON_TIME_LOW};
            onTimeB_q                       <= {`SPT_RST_ON_TIME_HIGH, `SPT_RST_ON_TIME_LOW};
            irqEnable_q                     <= 3'h0;
        end else if (doWrite && wrStrb_q) begin
            case (wrIdx_q)
                `SPT_IDX_POLL_CONTROL: begin
                    polling_variant_select_q        <= wrData_q[1:0];
                    active_idle_enable_q            <= wrData_q[`SPT_CTL_ACTIVE_IDLE];
                    continuous_wake_search_enable_q <= wrData_q[`SPT_CTL_CONT_SEARCH];
                end
                `SPT_IDX_TICK_DIVIDER:   reference_tick_reload_q <= wrData_q;
                `SPT_IDX_OFF_TIME_LOW:   off_time_setting_q[7:0] <= wrData_q;
                `SPT_IDX_OFF_TIME_HIGH:  off_time_setting_q[13:8] <= wrData_q[5:0];
                `SPT_IDX_ACTIVE_PERIODS: active_period_setting_q <= wrData_q[4:0];
                `SPT_IDX_IDLE_PERIODS:   idle_period_setting_q <= wrData_q;
                `SPT_IDX_MODE_CONTROL: begin
                    operating_mode_select_q <= wrData_q[`SPT_MODE_SELF_POLL];
                    dualConfig_q            <= wrData_q[`SPT_MODE_DUAL_CONFIG];
                end
                `SPT_IDX_ON_TIME_A_LOW:  onTimeA_q[7:0] <= wrData_q;
                `SPT_IDX_ON_TIME_A_HIGH: onTimeA_q[13:8] <= wrData_q[5:0];
                `SPT_IDX_ON_TIME_B_LOW:  onTimeB_q[7:0] <= wrData_q;
                `SPT_IDX_ON_TIME_B_HIGH: onTimeB_q[13:8] <= wrData_q[5:0];
                `SPT_IDX_IRQ_ENABLE:     irqEnable_q <= wrData_q[2:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Polling sequencer
    // ----------------------------------------------------------------
    assign onTimeCur = cfgB_q ? onTimeB_q : onTimeA_q;
    // Mixed variant: only configuration B falls back early
    assign fastCfg   = (polling_variant_select_q == `SPT_VAR_FAST_FALLBACK) ||
                       ((polling_variant_select_q == `SPT_VAR_MIXED) && cfgB_q);
    assign searching = continuous_wake_search_enable_q || activePhase_q;

    // On and off intervals alternate in reference ticks until wake-up or mode exit
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q              <= ST_STOP;
            cfgB_q               <= 1'b0;
            intervalCnt_q        <= 15'h0001;
            firstTick_q          <= 1'b0;
            found_channel_code_q <= `SPT_RST_FOUND_CHANNEL;
            events               <= 3'h0;
        end else begin
            events <= 3'h0;
            if (!operating_mode_select_q) begin
                state_q <= ST_STOP;
            end else begin
                case (state_q)
                    ST_STOP: begin
                        state_q              <= ST_ON;
                        cfgB_q               <= 1'b0;
                        intervalCnt_q        <= expand14(onTimeA_q);
                        firstTick_q          <= 1'b1;
                        found_channel_code_q <= 2'h0;
                        events[`SPT_IRQ_ON_START] <= 1'b1;
                    end
                    ST_ON: begin
                        if (wakeFound && searchOn_q) begin
                            state_q              <= ST_WOKEN;
                            found_channel_code_q <= wakeChannel;
                            events[`SPT_IRQ_WAKE_FOUND] <= 1'b1;
                        end else if (refTick) begin
                            firstTick_q   <= 1'b0;
                            intervalCnt_q <= intervalCnt_q - 15'h0001;
                            if (fastCfg && firstTick_q && !carrierSeen) begin
                                state_q       <= ST_OFF;
                                intervalCnt_q <= expand14(off_time_setting_q);
                                events[`SPT_IRQ_FALL_BACK] <= 1'b1;
                            end else if (intervalCnt_q <= 15'h0001) begin
                                state_q       <= ST_OFF;
                                intervalCnt_q <= expand14(off_time_setting_q);
                            end
                        end
                    end
                    ST_OFF: begin
                        if (refTick) begin
                            intervalCnt_q <= intervalCnt_q - 15'h0001;
                            if (intervalCnt_q <= 15'h0001) begin
                                state_q       <= ST_ON;
                                cfgB_q        <= dualConfig_q && !cfgB_q;
                                intervalCnt_q <= expand14((dualConfig_q && !cfgB_q) ? onTimeB_q : onTimeA_q);
                                firstTick_q   <= 1'b1;
                                events[`SPT_IRQ_ON_START] <= 1'b1;
                            end
                        end
                    end
                    ST_WOKEN: state_q <= ST_WOKEN;
                    default:  state_q <= ST_STOP;
                endcase
            end
        end
    end

    // Active and idle phases inside the on-time, counted in reference ticks
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            activePhase_q <= 1'b1;
            phaseCnt_q    <= 9'h001;
        end else if (state_q != ST_ON || !active_idle_enable_q) begin
            activePhase_q <= 1'b1;
            phaseCnt_q    <= expand8({3'h0, active_period_setting_q});
        end else if (refTick) begin
            if (phaseCnt_q <= 9'h001) begin
                activePhase_q <= !activePhase_q;
                phaseCnt_q    <= activePhase_q ? expand8(idle_period_setting_q)
                                               : expand8({3'h0, active_period_setting_q});
            end else begin
                phaseCnt_q <= phaseCnt_q - 9'h001;
            end
        end
    end

    // Registered receiver controls
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxOn_q     <= 1'b0;
            searchOn_q <= 1'b0;
        end else begin
            rxOn_q     <= (state_q == ST_ON);
            searchOn_q <= (state_q == ST_ON) && searching;
        end
    end

    assign receiverOn    = rxOn_q;
    assign wakeSearchOn  = searchOn_q;
    assign configBSelect = cfgB_q;

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    // A new event wins over a clear written in the same cycle
    always @* begin
        irqClear = 3'h0;
        if (doWrite && wrStrb_q && wrIdx_q == `SPT_IDX_IRQ_CLEAR) begin
            irqClear = wrData_q[2:0];
        end
        irqStatus_d = (irqStatus_q & ~irqClear) | events;
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irqStatus_q <= 3'h0;
            irq_q       <= 1'b0;
        end else begin
            irqStatus_q <= irqStatus_d;
            irq_q       <= |(irqStatus_d & irqEnable_q);
        end
    end

    assign irq = irq_q;

endmodule

// file: verilog/spt_defines.vh
// Register indices, field positions, reset values and timing figures of the self polling timing block
`ifndef SPT_DEFINES_VH
`define SPT_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SPT_IDX_FOUND_CHANNEL   6'h06
`define SPT_IDX_POLL_CONTROL    6'h07
`define SPT_IDX_TICK_DIVIDER    6'h08
`define SPT_IDX_OFF_TIME_LOW    6'h09
`define SPT_IDX_OFF_TIME_HIGH   6'h0A
`define SPT_IDX_ACTIVE_PERIODS  6'h0B
`define SPT_IDX_IDLE_PERIODS    6'h0C
`define SPT_IDX_SERIAL_BYTE0    6'h0E
`define SPT_IDX_MODE_CONTROL    6'h10
`define SPT_IDX_ON_TIME_A_LOW   6'h11
`define SPT_IDX_ON_TIME_A_HIGH  6'h12
`define SPT_IDX_ON_TIME_B_LOW   6'h13
`define SPT_IDX_ON_TIME_B_HIGH  6'h14
`define SPT_IDX_IRQ_STATUS      6'h15
`define SPT_IDX_IRQ_ENABLE      6'h16
`define SPT_IDX_IRQ_CLEAR       6'h17
`define SPT_IDX_SEQ_STATE       6'h18

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPT_RST_FOUND_CHANNEL   2'h0
`define SPT_RST_POLL_CONTROL    2'h0
`define SPT_RST_TICK_DIVIDER    8'h01
`define SPT_RST_OFF_TIME_LOW    8'h01
`define SPT_RST_OFF_TIME_HIGH   6'h00
`define SPT_RST_ACTIVE_PERIODS  5'h01
`define SPT_RST_IDLE_PERIODS    8'h01
`define SPT_RST_MODE_CONTROL    2'h0
`define SPT_RST_ON_TIME_LOW     8'h01
`define SPT_RST_ON_TIME_HIGH    6'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPT_CTL_CONT_SEARCH     3
`define SPT_CTL_ACTIVE_IDLE     2
`define SPT_MODE_SELF_POLL      0
`define SPT_MODE_DUAL_CONFIG    1
`define SPT_IRQ_WAKE_FOUND      0
`define SPT_IRQ_ON_START        1
`define SPT_IRQ_FALL_BACK       2

// ----------------------------------------------------------------
// Polling variants and timing
// ----------------------------------------------------------------
`define SPT_VAR_CONSTANT        2'h0
`define SPT_VAR_FAST_FALLBACK   2'h1
`define SPT_VAR_MIXED           2'h2
`define SPT_PRESCALE            64
`define SPT_RESP_OKAY           2'h0
`define SPT_RESP_SLVERR         2'h2

`endif

// file: verilog/spt_ref_tick.v
// Reference tick timer: fixed prescaler followed by a reloadable divider
`include "spt_defines.vh"
module spt_ref_tick #(
    parameter PRESCALE = `SPT_PRESCALE
) (
    input  wire       clock,
    input  wire       rst_n,
    input  wire       run,
    input  wire [7:0] reference_tick_reload,
    output wire       tick
);

    reg  [6:0] preCnt_q;
    reg  [8:0] divCnt_q;
    reg        tick_q;
    wire       preTick;
    wire [8:0] reloadFull;

    // Reload of zero stands for 256 prescaled ticks
    assign reloadFull = {(reference_tick_reload == 8'h00), reference_tick_reload};
    assign preTick    = (preCnt_q == PRESCALE[6:0] - 7'h01);
    assign tick       = tick_q;

    // Prescaler restarts from zero and divider from its reload while stopped, so the first period is whole
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            preCnt_q <= 7'h00;
            divCnt_q <= 9'h001;
            tick_q   <= 1'b0;
        end else if (!run) begin
            preCnt_q <= 7'h00;
            divCnt_q <= reloadFull;
            tick_q   <= 1'b0;
        end else begin
            preCnt_q <= preTick ? 7'h00 : preCnt_q + 7'h01;
            tick_q   <= preTick && (divCnt_q <= 9'h001);
            if (preTick) begin
                divCnt_q <= (divCnt_q <= 9'h001) ? reloadFull : divCnt_q - 9'h001;
            end
        end
    end

endmodule

// file: tb/spt_timing_sva.sv
// Port checker for the self polling timing block
module spt_timing_sva (
    input logic        clock,
    input logic        rst_n,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        receiverOn,
    input logic        wakeSearchOn
);
    // ------
    // Bus and sequencer relations
    // ------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_write_answer: // Store one cycle after both halves are taken, response the cycle after
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid |=> ##1 s_axi_bvalid) else $error("late bvalid");
    a_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("late rvalid");
    a_resp_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_data_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_read_free:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready) else $error("read stuck");
    a_upper_zero:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
    a_search_gate:
        assert property (wakeSearchOn |-> receiverOn) else $error("search outside on-time");
    a_on_min_tick:
        assert property ($rose(receiverOn) |=> receiverOn[*8]) else $error("on-time too short");
    // Main scenarios reached
    cover property ($rose(receiverOn));
    cover property ($fell(receiverOn));
    cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind spt_timing_regs spt_timing_sva chk (.*);

// file: tb/tb.sv
// Self-checking bench for the self polling timing block
`include "spt_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, wakeFound = 0, carrierSeen = 1;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  wakeChannel = 0;
    wire  [31:0] s_axi_rdata;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire         receiverOn, wakeSearchOn, configBSelect, irq;
    int          fail_count = 0, check_count = 0, n;
    // Serial byte set away from the default so a stuck value shows
    spt_timing_regs #(.SERIAL_NUMBER(8'hC3)) dut (.*);
    always #25 clock = ~clock;
    // ------
    // Helpers
    // ------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    // A used-up bound is a hang: count it and stop
    task automatic guard;
        if (n >= 20000) begin
            fail_count++;
            print_verdict();
        end
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] r = 2'h0);
        @(posedge clock);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 20000; n++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        guard();
        chk(s_axi_bresp, r);
    endtask
    task automatic rd(input logic [5:0] i, input logic [7:0] e, input logic [1:0] r = 2'h0);
        @(posedge clock);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 20000; n++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        guard();
        chk({s_axi_rresp, s_axi_rdata}, {r, 24'h0, e});
    endtask
    // Counts the cycles for which receiverOn keeps level v
    task automatic span(input logic v);
        for (n = 0; n < 20000 && receiverOn === v; n++) @(posedge clock);
        guard();
    endtask
    task automatic see_irq(input logic e);
        repeat (2) @(posedge clock);
        chk(irq, e);
    endtask
    // ------
    // Main sequence
    // ------
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'h1;
        rd(`SPT_IDX_FOUND_CHANNEL, 8'h00);
        rd(`SPT_IDX_SERIAL_BYTE0, 8'hC3);
        rd(`SPT_IDX_TICK_DIVIDER, 8'h00);
        rd(6'h3F, 8'h00, 2'h2);
        wr(6'h3F, 8'h01, 2'h2);
        $display("register access test done");
        wr(`SPT_IDX_OFF_TIME_LOW, 8'h02);
        wr(`SPT_IDX_OFF_TIME_HIGH, 8'h01);
        wr(`SPT_IDX_POLL_CONTROL, 8'h08);
        wr(`SPT_IDX_IRQ_ENABLE, 8'h01);
        wr(`SPT_IDX_MODE_CONTROL, 8'h01);
        span(1'h0);
        span(1'h1);
        span(1'h0);
        chk(n, 258 * `SPT_PRESCALE);
        span(1'h1);
        chk(n, `SPT_PRESCALE);
        span(1'h0);
        chk(configBSelect, 1'h0);
        $display("timing test done");
        // Let the on-time run past the shortest on-time the checker allows
        repeat (10) @(posedge clock);
        wakeChannel <= 2'h3;
        wakeFound <= 1'h1;
        repeat (2) @(posedge clock);
        wakeFound <= 1'h0;
        rd(`SPT_IDX_FOUND_CHANNEL, 8'h03);
        see_irq(1'h1);
        wr(`SPT_IDX_IRQ_ENABLE, 8'h00);
        see_irq(1'h0);
        wr(`SPT_IDX_IRQ_ENABLE, 8'h01);
        wr(`SPT_IDX_IRQ_CLEAR, 8'h01);
        see_irq(1'h0);
        rd(`SPT_IDX_IRQ_STATUS, 8'h02);
        $display("wake and interrupt test done");
        print_verdict();
    end
endmodule
